// ### dcdec_pkg.sv
package dcdec_pkg;

	// data widths
	localparam int SAMPLE_W = 14;
	localparam int DATA_W = 16;
	localparam int FREQ_W = 32;
	localparam int ADDR_W = 12;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PATH = 8'h24;
	localparam logic [7:0] IDX_DEC = 8'h25;
	localparam logic [7:0] IDX_MIX = 8'h26;
	localparam logic [7:0] IDX_FREQ_A = 8'h2a;
	localparam logic [7:0] IDX_FREQ_B = 8'h2e;
	localparam logic [7:0] IDX_STATUS = 8'h30;

	// digital_path_control fields
	localparam int AVG_EN_BIT = 5;
	localparam int SEL_LSB = 3;
	localparam int PATH_SEL_BIT = 2;
	localparam int DC_EN_BIT = 1;
	localparam logic [7:0] PATH_WMASK = 8'h3e;

	// decimation_control fields
	localparam int SEL_EN_BIT = 7;
	localparam int DEC_LSB = 4;
	localparam int REAL_BIT = 3;
	localparam int PH_INV_BIT = 0;
	localparam logic [7:0] DEC_WMASK = 8'hf9;

	// mixer_control fields
	localparam int GAIN_A_LSB = 6;
	localparam int PH_RST_A_BIT = 5;
	localparam int QMIX_A_BIT = 4;
	localparam int GAIN_B_LSB = 2;
	localparam int PH_RST_B_BIT = 1;
	localparam int QMIX_B_BIT = 0;
	localparam logic [7:0] MIX_WMASK = 8'hff;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;

	// filter input routing codes
	localparam logic [1:0] ROUTE_DIRECT = 2'h0;
	localparam logic [1:0] ROUTE_A_BOTH = 2'h1;
	localparam logic [1:0] ROUTE_B_BOTH = 2'h2;
	localparam logic [1:0] ROUTE_AVG = 2'h3;

	// decimation codes: 0 bypass, 1..5 divide by 2..32
	localparam logic [2:0] DEC_BYPASS = 3'h0;
	localparam logic [2:0] DEC_MAX = 3'h5;

	// mixer gain codes
	localparam logic [1:0] GAIN_NONE = 2'h0;
	localparam logic [1:0] GAIN_3DB = 2'h1;
	localparam logic [1:0] GAIN_6DB = 2'h2;

	// phase step for mixing at a quarter of the sample rate
	localparam logic [FREQ_W-1:0] QUARTER_STEP = 32'h4000_0000;

endpackage

// ### dcdec_mixer.sv
`timescale 1ns/1ps

module dcdec_mixer
	import dcdec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic signed [SAMPLE_W-1:0] sample_in,
	input wire logic sample_valid,
	input wire logic run,
	input wire logic real_mode,
	input wire logic quarter_rate,
	input wire logic phase_invert,
	input wire logic [1:0] gain,
	input wire logic phase_reset,
	input wire logic [FREQ_W-1:0] freq_word,
	output logic signed [DATA_W-1:0] mix_i,
	output logic signed [DATA_W-1:0] mix_q,
	output logic mix_valid,
	output logic [FREQ_W-1:0] phase
);

	logic [FREQ_W-1:0] active_freq;
	logic [FREQ_W-1:0] step;
	logic signed [DATA_W-1:0] ext;
	logic signed [DATA_W-1:0] next_i;
	logic signed [DATA_W-1:0] next_q;

	// gain after the mixer; 3 dB is 1+1/4+1/8+1/32, within 0.05 dB
	function automatic logic signed [DATA_W-1:0] apply_gain(input logic signed [DATA_W-1:0] x,
		input logic [1:0] g);
		logic signed [DATA_W-1:0] r;
		r = x;
		if (g == GAIN_3DB) begin
			r = x + (x >>> 2) + (x >>> 3) + (x >>> 5);
		end else if (g == GAIN_6DB) begin
			r = x <<< 1;
		end
		return r;
	endfunction

	// working frequency word changes only on a phase reset, forced to zero in real mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_freq <= FREQ_RESET;
		end else if (real_mode) begin
			active_freq <= FREQ_RESET;
		end else if (phase_reset) begin
			active_freq <= freq_word;
		end
	end

	assign step = (quarter_rate && !real_mode) ? QUARTER_STEP : active_freq;

	// phase accumulator of the oscillator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= FREQ_RESET;
		end else if (phase_reset) begin
			phase <= FREQ_RESET;
		end else if (run && sample_valid) begin
			phase <= phase + step;
		end
	end

	// quadrant mixer: coarse cosine and sine from the top two phase bits
	always_comb begin
		ext = DATA_W'(sample_in);
		next_i = ext;
		next_q = '0;
		if (!real_mode) begin
			unique case (phase[FREQ_W-1 -: 2])
				2'h0: begin
					next_i = ext;
					next_q = '0;
				end
				2'h1: begin
					next_i = '0;
					next_q = ext;
				end
				2'h2: begin
					next_i = -ext;
					next_q = '0;
				end
				2'h3: begin
					next_i = '0;
					next_q = -ext;
				end
			endcase
			if (phase_invert) begin
				next_q = -next_q;
			end
			next_i = apply_gain(next_i, gain);
			next_q = apply_gain(next_q, gain);
		end
	end

	// registered mixer output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mix_i <= '0;
			mix_q <= '0;
			mix_valid <= 1'b0;
		end else begin
			mix_i <= next_i;
			mix_q <= next_q;
			mix_valid <= run && sample_valid;
		end
	end

endmodule

// ### dcdec_decim.sv
`timescale 1ns/1ps

module dcdec_decim
	import dcdec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic in_valid,
	input wire logic signed [DATA_W-1:0] in_data,
	input wire logic [2:0] dec_code,
	output logic signed [DATA_W-1:0] out_data,
	output logic out_valid
);

	logic [4:0] count;
	logic [4:0] last;
	logic [2:0] shift;
	logic signed [DATA_W+4:0] acc;
	logic signed [DATA_W+4:0] sum;

	// unused codes fall back to bypass
	assign shift = (dec_code > DEC_MAX) ? DEC_BYPASS : dec_code;
	assign last = 5'((6'h01 << shift) - 6'h01);
	assign sum = acc + (DATA_W+5)'(in_data);

	// accumulate and dump: a box low-pass before keeping one sample in 2**shift
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			acc <= '0;
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (clear) begin
			count <= '0;
			acc <= '0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			if (in_valid) begin
				if (count >= last) begin
					count <= '0;
					acc <= '0;
					out_data <= DATA_W'(sum >>> shift);
					out_valid <= 1'b1;
				end else begin
					count <= count + 5'h01;
					acc <= sum;
				end
			end
		end
	end

endmodule

// ### dcdec_ctrl.sv
// The APB register port was decided locally.
`timescale 1ns/1ps

module dcdec_ctrl
	import dcdec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic signed [SAMPLE_W-1:0] sample_a,
	input wire logic signed [SAMPLE_W-1:0] sample_b,
	input wire logic sample_valid,
	output logic signed [DATA_W-1:0] filt_a_i,
	output logic signed [DATA_W-1:0] filt_a_q,
	output logic signed [DATA_W-1:0] filt_b_i,
	output logic signed [DATA_W-1:0] filt_b_q,
	output logic filt_valid
);

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] path_ctrl;
	logic [7:0] dec_ctrl;
	logic [7:0] mix_ctrl;
	logic [FREQ_W-1:0] freq_a;
	logic [FREQ_W-1:0] freq_b;
	logic [7:0] mix_ctrl_prev;
	logic [31:0] status;

	logic wr_en;
	logic setup;
	logic aligned;
	logic [7:0] idx;
	logic hit_path;
	logic hit_dec;
	logic hit_mix;
	logic hit_freq_a;
	logic hit_freq_b;
	logic hit_status;
	logic hit_any;

	// field views
	logic avg_en;
	logic [1:0] sel_code;
	logic path_sel;
	logic dc_en;
	logic sel_en;
	logic [2:0] dec_code;
	logic real_mode;
	logic ph_inv;
	logic [1:0] gain_a;
	logic [1:0] gain_b;
	logic qmix_a;
	logic qmix_b;
	logic ph_rst_a;
	logic ph_rst_b;

	// address decode; misaligned addresses never hit
	assign aligned = (paddr[1:0] == 2'b00);
	assign idx = paddr[9:2];
	assign hit_path = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_PATH);
	assign hit_dec = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_DEC);
	assign hit_mix = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_MIX);
	assign hit_freq_a = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_FREQ_A);
	assign hit_freq_b = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_FREQ_B);
	assign hit_status = aligned && (paddr[ADDR_W-1:10] == '0) && (idx == IDX_STATUS);
	assign hit_any = hit_path || hit_dec || hit_mix || hit_freq_a || hit_freq_b || hit_status;

	// zero wait states: the answer is ready in every access phase
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && hit_any;

	// control registers, reserved bits held at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path_ctrl <= CTRL_RESET;
			dec_ctrl <= CTRL_RESET;
			mix_ctrl <= CTRL_RESET;
		end else if (wr_en && pstrb[0]) begin
			if (hit_path) begin
				path_ctrl <= pwdata[7:0] & PATH_WMASK;
			end
			if (hit_dec) begin
				dec_ctrl <= pwdata[7:0] & DEC_WMASK;
			end
			if (hit_mix) begin
				mix_ctrl <= pwdata[7:0] & MIX_WMASK;
			end
		end
	end

	// frequency words; real mode wipes them so no stale tone survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_a <= FREQ_RESET;
			freq_b <= FREQ_RESET;
		end else if (real_mode) begin
			freq_a <= FREQ_RESET;
			freq_b <= FREQ_RESET;
		end else if (wr_en) begin
			for (int k = 0; k < 4; k++) begin
				if (pstrb[k] && hit_freq_a) begin
					freq_a[8*k +: 8] <= pwdata[8*k +: 8];
				end
				if (pstrb[k] && hit_freq_b) begin
					freq_b[8*k +: 8] <= pwdata[8*k +: 8];
				end
			end
		end
	end

	// previous copy of the mixer control, for toggle detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mix_ctrl_prev <= CTRL_RESET;
		end else begin
			mix_ctrl_prev <= mix_ctrl;
		end
	end

	assign avg_en = path_ctrl[AVG_EN_BIT];
	assign sel_code = path_ctrl[SEL_LSB +: 2];
	assign path_sel = path_ctrl[PATH_SEL_BIT];
	assign dc_en = path_ctrl[DC_EN_BIT];
	assign sel_en = dec_ctrl[SEL_EN_BIT];
	assign dec_code = dec_ctrl[DEC_LSB +: 3];
	assign real_mode = dec_ctrl[REAL_BIT];
	assign ph_inv = dec_ctrl[PH_INV_BIT];
	assign gain_a = mix_ctrl[GAIN_A_LSB +: 2];
	assign gain_b = mix_ctrl[GAIN_B_LSB +: 2];
	assign qmix_a = mix_ctrl[QMIX_A_BIT];
	assign qmix_b = mix_ctrl[QMIX_B_BIT];
	// either edge of the bit counts; it never clears itself
	assign ph_rst_a = mix_ctrl[PH_RST_A_BIT] ^ mix_ctrl_prev[PH_RST_A_BIT];
	assign ph_rst_b = mix_ctrl[PH_RST_B_BIT] ^ mix_ctrl_prev[PH_RST_B_BIT];

	////////////////////////////////////////////////////////////////////////////
	// read path: data and error are captured in the setup cycle

	logic [1:0] route_code;
	logic run;
	logic [FREQ_W-1:0] phase_a;
	logic [FREQ_W-1:0] phase_b;

	assign status = {8'h00, phase_b[FREQ_W-1 -: 8], phase_a[FREQ_W-1 -: 8],
		3'h0, real_mode, run, avg_en, route_code};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= !hit_any;
			prdata <= '0;
			if (!pwrite) begin
				if (hit_path) begin
					prdata <= {24'h0, path_ctrl};
				end else if (hit_dec) begin
					prdata <= {24'h0, dec_ctrl};
				end else if (hit_mix) begin
					prdata <= {24'h0, mix_ctrl};
				end else if (hit_freq_a) begin
					prdata <= freq_a;
				end else if (hit_freq_b) begin
					prdata <= freq_b;
				end else if (hit_status) begin
					prdata <= status;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input routing and averaging

	logic signed [SAMPLE_W:0] pair_sum;
	logic signed [SAMPLE_W-1:0] avg;
	logic signed [SAMPLE_W-1:0] next_route_a;
	logic signed [SAMPLE_W-1:0] next_route_b;
	logic signed [SAMPLE_W-1:0] route_a;
	logic signed [SAMPLE_W-1:0] route_b;
	logic route_valid;

	// the multiplexer only honours its code while enabled
	assign route_code = sel_en ? sel_code : ROUTE_DIRECT;

	// one extra bit keeps the sum exact before the halving
	assign pair_sum = (SAMPLE_W+1)'(sample_a) + (SAMPLE_W+1)'(sample_b);
	assign avg = SAMPLE_W'(pair_sum >>> 1);

	always_comb begin
		next_route_a = sample_a;
		next_route_b = sample_b;
		unique case (route_code)
			ROUTE_DIRECT: begin
				next_route_a = sample_a;
				next_route_b = sample_b;
			end
			ROUTE_A_BOTH: begin
				next_route_a = sample_a;
				next_route_b = sample_a;
			end
			ROUTE_B_BOTH: begin
				next_route_a = sample_b;
				next_route_b = sample_b;
			end
			ROUTE_AVG: begin
				// without averaging enabled the stage passes channels straight
				if (avg_en) begin
					next_route_a = avg;
					next_route_b = avg;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_a <= '0;
			route_b <= '0;
			route_valid <= 1'b0;
		end else begin
			route_a <= next_route_a;
			route_b <= next_route_b;
			route_valid <= sample_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mixers and decimation filters

	logic signed [DATA_W-1:0] mix_a_i;
	logic signed [DATA_W-1:0] mix_a_q;
	logic signed [DATA_W-1:0] mix_b_i;
	logic signed [DATA_W-1:0] mix_b_q;
	logic mix_a_valid;
	logic mix_b_valid;
	logic signed [DATA_W-1:0] dec_a_i;
	logic signed [DATA_W-1:0] dec_a_q;
	logic signed [DATA_W-1:0] dec_b_i;
	logic signed [DATA_W-1:0] dec_b_q;
	logic dec_a_valid;
	logic dec_b_valid;

	// both filters share one enable and need the feature path
	assign run = path_sel && dc_en;

	dcdec_mixer mixer_a (
		.pclk(pclk),
		.presetn(presetn),
		.sample_in(route_a),
		.sample_valid(route_valid),
		.run(run),
		.real_mode(real_mode),
		.quarter_rate(qmix_a),
		.phase_invert(ph_inv),
		.gain(gain_a),
		.phase_reset(ph_rst_a),
		.freq_word(freq_a),
		.mix_i(mix_a_i),
		.mix_q(mix_a_q),
		.mix_valid(mix_a_valid),
		.phase(phase_a)
	);

	dcdec_mixer mixer_b (
		.pclk(pclk),
		.presetn(presetn),
		.sample_in(route_b),
		.sample_valid(route_valid),
		.run(run),
		.real_mode(real_mode),
		.quarter_rate(qmix_b),
		.phase_invert(ph_inv),
		.gain(gain_b),
		.phase_reset(ph_rst_b),
		.freq_word(freq_b),
		.mix_i(mix_b_i),
		.mix_q(mix_b_q),
		.mix_valid(mix_b_valid),
		.phase(phase_b)
	);

	// the q filters run in lock step with the i filters, so their valid is left open
	dcdec_decim decim_a_i (.pclk(pclk), .presetn(presetn), .clear(!run), .in_valid(mix_a_valid),
		.in_data(mix_a_i), .dec_code(dec_code), .out_data(dec_a_i), .out_valid(dec_a_valid));

	dcdec_decim decim_a_q (.pclk(pclk), .presetn(presetn), .clear(!run), .in_valid(mix_a_valid),
		.in_data(mix_a_q), .dec_code(dec_code), .out_data(dec_a_q), .out_valid());

	dcdec_decim decim_b_i (.pclk(pclk), .presetn(presetn), .clear(!run), .in_valid(mix_b_valid),
		.in_data(mix_b_i), .dec_code(dec_code), .out_data(dec_b_i), .out_valid(dec_b_valid));

	dcdec_decim decim_b_q (.pclk(pclk), .presetn(presetn), .clear(!run), .in_valid(mix_b_valid),
		.in_data(mix_b_q), .dec_code(dec_code), .out_data(dec_b_q), .out_valid());

	////////////////////////////////////////////////////////////////////////////
	// output selection

	// bypass takes raw samples for one-cycle latency; feature path without
	// filters passes the routed samples as real data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_a_i <= '0;
			filt_a_q <= '0;
			filt_b_i <= '0;
			filt_b_q <= '0;
			filt_valid <= 1'b0;
		end else if (!path_sel) begin
			filt_a_i <= DATA_W'(sample_a);
			filt_a_q <= '0;
			filt_b_i <= DATA_W'(sample_b);
			filt_b_q <= '0;
			filt_valid <= sample_valid;
		end else if (!dc_en) begin
			filt_a_i <= DATA_W'(route_a);
			filt_a_q <= '0;
			filt_b_i <= DATA_W'(route_b);
			filt_b_q <= '0;
			filt_valid <= route_valid;
		end else begin
			filt_a_i <= dec_a_i;
			filt_a_q <= dec_a_q;
			filt_b_i <= dec_b_i;
			filt_b_q <= dec_b_q;
			filt_valid <= dec_a_valid && dec_b_valid;
		end
	end

endmodule

// ### dcdec_ctrl_checker.sv
`timescale 1ns/1ps

module dcdec_ctrl_checker
	import dcdec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic signed [SAMPLE_W-1:0] sample_a,
	input wire logic signed [SAMPLE_W-1:0] sample_b,
	input wire logic sample_valid,
	input wire logic signed [DATA_W-1:0] filt_a_i,
	input wire logic signed [DATA_W-1:0] filt_a_q,
	input wire logic signed [DATA_W-1:0] filt_b_i,
	input wire logic signed [DATA_W-1:0] filt_b_q,
	input wire logic filt_valid
);
	logic [7:0] path_r;
	logic [7:0] dec_r;
	logic feat;
	logic filt_on;
	logic sel_on;
	logic [1:0] code;
	logic [2:0] dec;

	////////////////////////////////////////
	// shadow of two control registers, taken on the same access edge as the design
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path_r <= 8'h00;
			dec_r <= 8'h00;
		end else if (psel && penable && pwrite && pready) begin
			if (paddr == 12'h090) path_r <= pwdata[7:0];
			if (paddr == 12'h094) dec_r <= pwdata[7:0];
		end
	end

	// decoded views; the filters only count as running inside the feature path
	assign feat = path_r[PATH_SEL_BIT];
	assign filt_on = feat && path_r[DC_EN_BIT];
	assign sel_on = dec_r[SEL_EN_BIT];
	assign code = path_r[SEL_LSB+:2];
	assign dec = dec_r[DEC_LSB+:3];

	////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a sample entering the feature path with the filters off
	sequence s_feat_in;
		feat && !filt_on && sample_valid;
	endsequence
	// a sample entering a running filter that does not decimate
	sequence s_full_in;
		filt_on && dec == DEC_BYPASS && sample_valid;
	endsequence

	property p_byp_lat;
		!feat && sample_valid |=> filt_valid && filt_a_i == DATA_W'($past(sample_a))
			&& filt_b_i == DATA_W'($past(sample_b));
	endproperty
	a_byp_lat: assert property (p_byp_lat) else $error("bypass output wrong or late");
	property p_feat_lat;
		s_feat_in |-> ##2 filt_valid;
	endproperty
	a_feat_lat: assert property (p_feat_lat) else $error("disabled filter did not pass sample");
	property p_full_lat;
		s_full_in |-> ##4 filt_valid;
	endproperty
	a_full_lat: assert property (p_full_lat) else $error("full rate filter output late");
	// with groups of two or more, outputs can never come in adjacent cycles
	property p_dec_gap;
		filt_on && dec != DEC_BYPASS && dec <= DEC_MAX && filt_valid |=> !filt_valid;
	endproperty
	a_dec_gap: assert property (p_dec_gap) else $error("decimated outputs too close");
	property p_real_q;
		filt_on && dec_r[REAL_BIT] && filt_valid |-> filt_a_q == 0 && filt_b_q == 0;
	endproperty
	a_real_q: assert property (p_real_q) else $error("real mode produced quadrature data");
	property p_a_both;
		s_feat_in ##0 (sel_on && code == ROUTE_A_BOTH) |-> ##2 filt_a_i == DATA_W'($past(sample_a, 2))
			&& filt_b_i == filt_a_i;
	endproperty
	a_a_both: assert property (p_a_both) else $error("channel a not on both filters");
	property p_b_both;
		s_feat_in ##0 (sel_on && code == ROUTE_B_BOTH) |-> ##2 filt_b_i == DATA_W'($past(sample_b, 2))
			&& filt_a_i == filt_b_i;
	endproperty
	a_b_both: assert property (p_b_both) else $error("channel b not on both filters");
	property p_straight;
		s_feat_in ##0 !sel_on |-> ##2 filt_a_i == DATA_W'($past(sample_a, 2))
			&& filt_b_i == DATA_W'($past(sample_b, 2));
	endproperty
	a_straight: assert property (p_straight) else $error("routing not straight with select off");
	property p_avg;
		s_feat_in ##0 (sel_on && code == ROUTE_AVG && path_r[AVG_EN_BIT]) |-> ##2 filt_b_i == filt_a_i
			&& filt_a_i == ((DATA_W'($past(sample_a, 2)) + DATA_W'($past(sample_b, 2))) >>> 1);
	endproperty
	a_avg: assert property (p_avg) else $error("average stage output wrong");
	property p_rst_quiet;
		$rose(presetn) |-> !filt_valid && filt_a_i == 0 && filt_b_i == 0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not clear after reset");
endmodule

bind dcdec_ctrl dcdec_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .sample_a(sample_a), .sample_b(sample_b),
	.sample_valid(sample_valid), .filt_a_i(filt_a_i), .filt_a_q(filt_a_q), .filt_b_i(filt_b_i),
	.filt_b_q(filt_b_q), .filt_valid(filt_valid));

// ### dcdec_conv.sv
`timescale 1ns/1ps

module dcdec_conv
	import dcdec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [6:0] count,
	input wire logic signed [SAMPLE_W-1:0] val_a,
	input wire logic signed [SAMPLE_W-1:0] val_b,
	output logic signed [SAMPLE_W-1:0] sample_a,
	output logic signed [SAMPLE_W-1:0] sample_b,
	output logic sample_valid,
	output logic busy
);
	logic [6:0] left;

	////////////////////////////////////////
	// both cores share one conversion clock, so a burst is one pair per cycle;
	// idle data toggles so a design that samples without valid sees garbage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 7'h00;
			sample_valid <= 1'b0;
			sample_a <= '0;
			sample_b <= '0;
		end else begin
			sample_valid <= (left != 7'h00);
			sample_a <= (left != 7'h00) ? val_a : ~sample_a;
			sample_b <= (left != 7'h00) ? val_b : ~sample_b;
			left <= start ? count : left - 7'((left != 7'h00));
		end
	end

	// busy until the last pair has been presented
	assign busy = (left != 7'h00) || sample_valid;
endmodule

// ### dual_channel_decimation_control_tb.sv
`timescale 1ns/1ps

module dual_channel_decimation_control_tb
	import dcdec_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, sv, fv, busy, re;
	logic [31:0] prdata, rq;
	logic signed [SAMPLE_W-1:0] sa, sb;
	logic signed [DATA_W-1:0] ai, aq, bi, bq;
	logic start = 1'b0;
	logic [6:0] nreq = 7'h00;
	logic signed [SAMPLE_W-1:0] va = '0;
	logic signed [SAMPLE_W-1:0] vb = '0;
	logic signed [31:0] ga, gaq, gb;
	int nout = 0;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	logic [11:0] ra [6] = '{12'h090, 12'h094, 12'h098, 12'h0a8, 12'h0b8, 12'h0c0};
	logic [7:0] wm [3] = '{8'h3e, 8'hf9, 8'hff};
	logic [7:0] pm [4] = '{8'h04, 8'h0c, 8'h14, 8'h3c};
	int ea [4] = '{100, 100, -40, 30};
	int eb [4] = '{-40, 100, -40, 30};

	dcdec_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sample_a(sa), .sample_b(sb), .sample_valid(sv), .filt_a_i(ai), .filt_a_q(aq), .filt_b_i(bi),
		.filt_b_q(bq), .filt_valid(fv));
	dcdec_conv conv_u (.pclk(pclk), .presetn(presetn), .start(start), .count(nreq), .val_a(va), .val_b(vb),
		.sample_a(sa), .sample_b(sb), .sample_valid(sv), .busy(busy));

	////////////////////////////////////////
	// clock, and a cycle ceiling well above the few hundred cycles needed
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			summarize();
		end
	end

	// capture mid-cycle, where the one-cycle valid pulse has settled
	always @(negedge pclk) begin
		if (fv === 1'b1) begin
			ga = ai;
			gaq = aq;
			gb = bi;
			nout++;
		end
	end

	////////////////////////////////////////
	task summarize();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one apb transfer; request held until pready is seen high at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rq, e);
	endtask

	// burst of n sample pairs, then compare the last output pair
	task go(input int n, input int a, input int b, input int xa, input int xb);
		nout = 0;
		ga = 'x;
		gb = 'x;
		gaq = 'x;
		@(posedge pclk);
		va <= SAMPLE_W'(a);
		vb <= SAMPLE_W'(b);
		nreq <= 7'(n);
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		@(posedge pclk);
		while (busy) @(posedge pclk);
		repeat (6) @(posedge pclk);
		chk(ga, xa);
		chk(gb, xb);
	endtask

	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(ra[i], 32'h0);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, ra[i], 32'hff);
			rd(ra[i], 32'(wm[i]));
			xfer(1'b1, ra[i], 32'h0);
		end
		rd(12'h0fc, 32'h0);
		chk(32'(re), 32'h1);
		go(1, 100, -50, 100, -50);
		xfer(1'b1, ra[1], 32'h80);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, ra[0], 32'(pm[k]));
			go(1, 100, -40, ea[k], eb[k]);
		end
		xfer(1'b1, ra[0], 32'h3e);
		go(1, 100, -40, 30, 30);
		xfer(1'b1, ra[0], 32'h1e);
		go(1, 100, -40, 100, -40);
		xfer(1'b1, ra[1], 32'h10);
		xfer(1'b1, ra[0], 32'h0c);
		go(2, 100, -40, 100, -40);
		chk(32'(nout), 32'h2);
		xfer(1'b1, ra[0], 32'h06);
		for (int k = 0; k < 6; k++) begin
			xfer(1'b1, ra[1], 32'(k << 4));
			go(1 << k, 64, -32, 64, -32);
			chk(32'(nout), 32'h1);
		end
		xfer(1'b1, ra[1], 32'h0);
		xfer(1'b1, ra[2], 32'h84);
		go(1, 64, 64, 128, 90);
		xfer(1'b1, ra[1], 32'h08);
		xfer(1'b1, ra[4], 32'h0);
		xfer(1'b1, ra[3], 32'h1234_5678);
		rd(ra[3], 32'h0);
		go(1, 64, -32, 64, -32);
		chk(gaq, 32'h0);
		// a full turn in four samples averages to zero, whatever the start phase
		xfer(1'b1, ra[1], 32'h20);
		xfer(1'b1, ra[2], 32'h0);
		xfer(1'b1, ra[3], 32'h4000_0000);
		rd(ra[3], 32'h4000_0000);
		go(4, 64, 64, 64, 64);
		xfer(1'b1, ra[2], 32'h20);
		go(4, 64, 64, 0, 64);
		xfer(1'b1, ra[2], 32'h21);
		go(4, 64, 64, 0, 0);
		// invert touches only q; both phase resets restart at quadrant 0, a turns by quarter rate alone
		xfer(1'b1, ra[1], 32'h01);
		go(1, 64, 64, 64, 64);
		xfer(1'b1, ra[3], 32'h0);
		xfer(1'b1, ra[2], 32'h13);
		go(2, 64, 64, 0, 0);
		chk(gaq, 32'hffff_ffc0);
		summarize();
	end
endmodule
